// >>> rtl/asq_pkg.sv
`default_nettype none
package asq_pkg;
    // register port geometry
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int RES_W = 10;

    // register offsets
    localparam logic [2:0] OFF_CTRL = 3'h0;
    localparam logic [2:0] OFF_PORT_CFG = 3'h1;
    localparam logic [2:0] OFF_TIMING = 3'h2;
    localparam logic [2:0] OFF_RES_HI = 3'h3;
    localparam logic [2:0] OFF_RES_LO = 3'h4;
    localparam logic [2:0] OFF_FLAGS = 3'h5;

    // field positions
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_CHAN_LSB = 2;
    localparam int PCFG_LSB = 0;
    localparam int VREF_POS_BIT = 4;
    localparam int VREF_NEG_BIT = 5;
    localparam int JUSTIFY_BIT = 7;
    localparam int ACQ_SEL_LSB = 3;
    localparam int CLK_SEL_LSB = 0;
    localparam int FLAG_DONE_BIT = 0;
    localparam int FLAG_IRQ_EN_BIT = 1;

    // writable masks and reset values
    localparam logic [7:0] TIMING_MASK = 8'hbf;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PORT_CFG_RESET = 8'h00;
    localparam logic [7:0] TIMING_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // timing
    localparam int SYS_CLK_PERIOD_NS = 50;
    localparam int INSTR_CYCLE_NS = 200;
    localparam int RC_DELAY_INT = (INSTR_CYCLE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam logic [2:0] RC_DELAY_CLKS = 3'(RC_DELAY_INT);
    localparam logic [4:0] CONV_TADS = 5'h0b;
    localparam logic [4:0] SAR_DECISIONS = 5'h0a;
    localparam logic [4:0] POST_WAIT_TADS = 5'h03;
    localparam logic [9:0] SAR_FIRST = 10'h200;
    localparam logic [1:0] RC_CODE = 2'h3;

    // acquisition length per select code, in conversion clock periods
    localparam logic [4:0] ACQ_TADS [8] = '{5'h00, 5'h02, 5'h04, 5'h06,
                                            5'h08, 5'h0c, 5'h10, 5'h14};
    // system clock divide ratio per select code; rc codes unused
    localparam logic [6:0] DIV_RATIO [8] = '{7'h02, 7'h08, 7'h20, 7'h01,
                                             7'h04, 7'h10, 7'h40, 7'h01};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ = 2'b01,
        ST_CONV = 2'b10,
        ST_RECOVER = 2'b11
    } asq_state_e;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } asq_bus_req_s;

    typedef struct packed {
        logic sample_connect;
        logic vref_pos_ext;
        logic vref_neg_ext;
        logic [3:0] channel;
        logic [3:0] port_cfg;
        logic [9:0] sar_trial;
    } asq_analog_s;

    // {result_high_byte, result_low_byte}
    function automatic logic [15:0] asq_justify(input logic [9:0] code, input logic right);
        logic [15:0] r;
        r = right ? {6'h00, code} : {code, 6'h00};
        return r;
    endfunction
endpackage
`default_nettype wire

// >>> rtl/asq_tad_gen.sv
`default_nettype none
module asq_tad_gen (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // control
    input wire logic run,
    input wire logic [2:0] clk_sel,
    input wire logic rc_tick,
    input wire logic sleep_active,
    // conversion clock period strobe
    output logic tad_tick
);
    logic [6:0] div_cnt_reg;
    logic [6:0] div_cnt_next;
    logic [2:0] dly_cnt_reg;
    logic [2:0] dly_cnt_next;
    logic run_d_reg;

    wire logic [6:0] div_last = 7'(asq_pkg::DIV_RATIO[clk_sel] - 7'h01);
    wire logic is_rc = clk_sel[1:0] == asq_pkg::RC_CODE;
    wire logic start_edge = run && !run_d_reg;
    // sleep gating
    // the system clock stops in sleep; only the rc source keeps going
    wire logic clock_ok = !sleep_active || is_rc;
    wire logic div_hit = div_cnt_reg == div_last;

    assign dly_cnt_next = (start_edge && is_rc) ? asq_pkg::RC_DELAY_CLKS :
                          (dly_cnt_reg != 3'h0) ? 3'(dly_cnt_reg - 3'h1) : 3'h0;
    assign div_cnt_next = (!run || start_edge || !clock_ok || div_hit) ? 7'h00 :
                          7'(div_cnt_reg + 7'h01);
    assign tad_tick = run && !start_edge && clock_ok &&
                      (is_rc ? (rc_tick && dly_cnt_reg == 3'h0) : div_hit);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt_reg <= 7'h00;
            dly_cnt_reg <= 3'h0;
            run_d_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            dly_cnt_reg <= dly_cnt_next;
            run_d_reg <= run;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    rc_start_delay_a: assert property ($rose(run) && is_rc && !sleep_active |->
        !tad_tick [*5])
        else $error("rc conversion clock started without delay");
    sleep_gate_a: assert property (sleep_active && !is_rc |-> !tad_tick)
        else $error("divided clock ticked during sleep");
    div_restart_a: assert property (tad_tick && !is_rc && run |=> div_cnt_reg == 7'h00)
        else $error("divider did not restart after a period");
endmodule
`default_nettype wire

// >>> rtl/asq_sequencer.sv
`default_nettype none
module asq_sequencer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire asq_pkg::asq_bus_req_s bus_req,
    output logic [7:0] rd_data,
    // analog front end
    input wire logic comp_above,
    input wire logic rc_tick,
    input wire logic sleep_active,
    output wire asq_pkg::asq_analog_s ana_out,
    // completion
    output logic conversion_done_flag,
    output logic conversion_irq_enable
);
    // control state
    logic converter_on_reg;
    logic start_reg;
    logic start_next;
    logic [3:0] chan_reg;
    logic [5:0] port_cfg_reg;
    logic [7:0] timing_reg;
    logic done_flag_reg;
    logic done_flag_next;
    logic irq_en_reg;
    logic [7:0] res_hi_reg;
    logic [7:0] res_lo_reg;
    logic [7:0] rd_data_reg;
    asq_pkg::asq_state_e state_reg;
    asq_pkg::asq_state_e state_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic [9:0] sar_reg;
    logic [9:0] sar_next;
    logic [9:0] mask_reg;
    logic [9:0] mask_next;
    logic tad_tick;

    // register decode
    wire logic wr_ctrl = bus_req.wr && bus_req.addr == asq_pkg::OFF_CTRL;
    wire logic wr_port = bus_req.wr && bus_req.addr == asq_pkg::OFF_PORT_CFG;
    wire logic wr_timing = bus_req.wr && bus_req.addr == asq_pkg::OFF_TIMING;
    wire logic wr_res_hi = bus_req.wr && bus_req.addr == asq_pkg::OFF_RES_HI;
    wire logic wr_res_lo = bus_req.wr && bus_req.addr == asq_pkg::OFF_RES_LO;
    wire logic wr_flags = bus_req.wr && bus_req.addr == asq_pkg::OFF_FLAGS;

    // timing fields
    // justify select
    wire logic justify_right = timing_reg[asq_pkg::JUSTIFY_BIT];
    wire logic [2:0] acq_time_select = timing_reg[asq_pkg::ACQ_SEL_LSB +: 3];
    wire logic [2:0] conv_clock_select = timing_reg[asq_pkg::CLK_SEL_LSB +: 3];
    wire logic [4:0] acq_len = asq_pkg::ACQ_TADS[acq_time_select];
    wire logic [4:0] cnt_inc = 5'(cnt_reg + 5'h01);

    // sequencing events
    wire logic busy = state_reg == asq_pkg::ST_ACQ || state_reg == asq_pkg::ST_CONV;
    wire logic go_req = state_reg == asq_pkg::ST_IDLE && start_reg && converter_on_reg;
    wire logic acq_end = state_reg == asq_pkg::ST_ACQ && start_reg && tad_tick &&
                         cnt_inc == acq_len;
    wire logic done_pulse = state_reg == asq_pkg::ST_CONV && start_reg && tad_tick &&
                            cnt_reg == 5'(asq_pkg::CONV_TADS - 5'h01);
    wire logic abort = busy && !start_reg;
    wire logic recover_end = state_reg == asq_pkg::ST_RECOVER && tad_tick &&
                             cnt_inc == asq_pkg::POST_WAIT_TADS;
    wire logic [15:0] res_word = asq_pkg::asq_justify(sar_reg, justify_right);

    // start ignored while off
    // start is only accepted when the converter was already on before this write
    wire logic sw_start = wr_ctrl && converter_on_reg && bus_req.wdata[asq_pkg::CTRL_ON_BIT] &&
                          bus_req.wdata[asq_pkg::CTRL_START_BIT];

    // start stays set while acquisition hands over to conversion
    assign start_next = !converter_on_reg ? 1'b0 :
                        done_pulse ? 1'b0 :
                        wr_ctrl ? sw_start : start_reg;
    // done flag set wins over clear
    assign done_flag_next = done_pulse ||
                            (wr_flags ? bus_req.wdata[asq_pkg::FLAG_DONE_BIT] : done_flag_reg);

    // zero acquisition goes straight to conversion
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            asq_pkg::ST_IDLE: begin
                if (go_req) begin
                    state_next = (acq_len == 5'h00) ? asq_pkg::ST_CONV : asq_pkg::ST_ACQ;
                end
            end
            asq_pkg::ST_ACQ: begin
                if (abort) begin
                    state_next = asq_pkg::ST_RECOVER;
                end else if (acq_end) begin
                    state_next = asq_pkg::ST_CONV;
                end
            end
            asq_pkg::ST_CONV: begin
                if (abort || done_pulse) begin
                    state_next = asq_pkg::ST_RECOVER;
                end
            end
            asq_pkg::ST_RECOVER: begin
                if (recover_end) begin
                    state_next = asq_pkg::ST_IDLE;
                end
            end
        endcase
        if (!converter_on_reg) begin
            state_next = asq_pkg::ST_IDLE;
        end
    end

    assign cnt_next = (state_next != state_reg) ? 5'h00 :
                      tad_tick ? cnt_inc : cnt_reg;

    // successive approximation
    // one decision per period, msb first; the trial code drives the dac
    wire logic enter_conv = state_next == asq_pkg::ST_CONV && state_reg != asq_pkg::ST_CONV;
    wire logic decide = state_reg == asq_pkg::ST_CONV && tad_tick &&
                        cnt_reg < asq_pkg::SAR_DECISIONS;
    wire logic [9:0] sar_decided = (sar_reg & ~mask_reg) | (comp_above ? mask_reg : 10'h000);
    assign sar_next = enter_conv ? asq_pkg::SAR_FIRST :
                      decide ? (sar_decided | (mask_reg >> 1)) : sar_reg;
    assign mask_next = enter_conv ? asq_pkg::SAR_FIRST :
                       decide ? (mask_reg >> 1) : mask_reg;

    // read mux
    // start flag shows busy
    wire logic [7:0] ctrl_view = {2'h0, chan_reg, start_reg, converter_on_reg};
    wire logic [7:0] flags_view = {6'h00, irq_en_reg, done_flag_reg};
    wire logic [7:0] rd_word = (bus_req.addr == asq_pkg::OFF_CTRL) ? ctrl_view :
                               (bus_req.addr == asq_pkg::OFF_PORT_CFG) ? {2'h0, port_cfg_reg} :
                               (bus_req.addr == asq_pkg::OFF_TIMING) ? timing_reg :
                               (bus_req.addr == asq_pkg::OFF_RES_HI) ? res_hi_reg :
                               (bus_req.addr == asq_pkg::OFF_RES_LO) ? res_lo_reg :
                               (bus_req.addr == asq_pkg::OFF_FLAGS) ? flags_view :
                               asq_pkg::READ_IDLE;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            converter_on_reg <= asq_pkg::CTRL_RESET[asq_pkg::CTRL_ON_BIT];
            start_reg <= asq_pkg::CTRL_RESET[asq_pkg::CTRL_START_BIT];
            chan_reg <= asq_pkg::CTRL_RESET[asq_pkg::CTRL_CHAN_LSB +: 4];
            port_cfg_reg <= asq_pkg::PORT_CFG_RESET[5:0];
            timing_reg <= asq_pkg::TIMING_RESET;
            done_flag_reg <= 1'b0;
            irq_en_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                converter_on_reg <= bus_req.wdata[asq_pkg::CTRL_ON_BIT];
                chan_reg <= bus_req.wdata[asq_pkg::CTRL_CHAN_LSB +: 4];
            end
            if (wr_port) begin
                port_cfg_reg <= bus_req.wdata[5:0];
            end
            if (wr_timing) begin
                timing_reg <= bus_req.wdata & asq_pkg::TIMING_MASK;
            end
            if (wr_flags) begin
                irq_en_reg <= bus_req.wdata[asq_pkg::FLAG_IRQ_EN_BIT];
            end
            start_reg <= start_next;
            done_flag_reg <= done_flag_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= asq_pkg::ST_IDLE;
            cnt_reg <= 5'h00;
            sar_reg <= 10'h000;
            mask_reg <= 10'h000;
            rd_data_reg <= asq_pkg::READ_IDLE;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sar_reg <= sar_next;
            mask_reg <= mask_next;
            rd_data_reg <= bus_req.rd ? rd_word : asq_pkg::READ_IDLE;
        end
    end

    // result kept over reset
    // no reset on purpose: the pair holds whatever it had until loaded
    always_ff @(posedge sys_clk) begin
        if (done_pulse) begin
            res_hi_reg <= res_word[15:8];
            res_lo_reg <= res_word[7:0];
        end else begin
            if (wr_res_hi) begin
                res_hi_reg <= bus_req.wdata;
            end
            if (wr_res_lo) begin
                res_lo_reg <= bus_req.wdata;
            end
        end
    end

    asq_tad_gen u_tad_gen (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(converter_on_reg && state_reg != asq_pkg::ST_IDLE),
        .clk_sel(conv_clock_select),
        .rc_tick(rc_tick),
        .sleep_active(sleep_active),
        .tad_tick(tad_tick)
    );

    assign ana_out = '{
        sample_connect: converter_on_reg &&
                        (state_reg == asq_pkg::ST_IDLE || state_reg == asq_pkg::ST_ACQ),
        vref_pos_ext: port_cfg_reg[asq_pkg::VREF_POS_BIT],
        vref_neg_ext: port_cfg_reg[asq_pkg::VREF_NEG_BIT],
        channel: chan_reg,
        port_cfg: port_cfg_reg[asq_pkg::PCFG_LSB +: 4],
        sar_trial: sar_reg
    };
    assign rd_data = rd_data_reg;
    assign conversion_done_flag = done_flag_reg;
    assign conversion_irq_enable = irq_en_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    fmt_right_a: assert property (done_pulse && justify_right |=>
        res_hi_reg == {6'h00, $past(sar_reg[9:8])} && res_lo_reg == $past(sar_reg[7:0]))
        else $error("right justified result misplaced");
    fmt_left_a: assert property (done_pulse && !justify_right |=>
        res_hi_reg == $past(sar_reg[9:2]) && res_lo_reg == {$past(sar_reg[1:0]), 6'h00})
        else $error("left justified result misplaced");
    acq_length_a: assert property (state_reg == asq_pkg::ST_ACQ && start_reg && tad_tick
        |-> ((state_next == asq_pkg::ST_CONV) == (cnt_inc == acq_len)))
        else $error("acquisition length does not match the select code");
    done_effects_a: assert property (done_pulse |=>
        !start_reg && done_flag_reg && state_reg == asq_pkg::ST_RECOVER)
        else $error("completion did not clear start and set done");
    recover_wait_a: assert property (
        state_reg == asq_pkg::ST_RECOVER && state_next == asq_pkg::ST_IDLE && converter_on_reg
        |-> tad_tick && cnt_reg == 5'(asq_pkg::POST_WAIT_TADS - 5'h01))
        else $error("recovery shorter than three periods");
    direct_conv_a: assert property (go_req && acq_time_select == 3'h0 |=>
        state_reg == asq_pkg::ST_CONV && !ana_out.sample_connect)
        else $error("zero acquisition did not convert at once");
    hold_open_a: assert property (state_reg == asq_pkg::ST_CONV |->
        !ana_out.sample_connect)
        else $error("hold capacitor connected during conversion");
    conv_len_a: assert property (done_pulse |->
        tad_tick && cnt_reg == 5'(asq_pkg::CONV_TADS - 5'h01))
        else $error("conversion length is not eleven periods");
    abort_keep_a: assert property (abort && converter_on_reg && !wr_res_hi && !wr_res_lo
        |=> res_hi_reg == $past(res_hi_reg) && res_lo_reg == $past(res_lo_reg) &&
        state_reg == asq_pkg::ST_RECOVER)
        else $error("abort disturbed the result");
    off_idle_a: assert property (!converter_on_reg |=>
        !start_reg && state_reg == asq_pkg::ST_IDLE)
        else $error("converter busy while switched off");
    resume_sample_a: assert property (state_reg == asq_pkg::ST_RECOVER &&
        state_next == asq_pkg::ST_IDLE && converter_on_reg && !wr_ctrl
        |=> ana_out.sample_connect)
        else $error("sampling did not resume after recovery");

    cover_auto_acq_c: cover property (done_pulse && acq_len != 5'h00);
    cover_abort_c: cover property (abort && state_reg == asq_pkg::ST_CONV);
    cover_rc_done_c: cover property (done_pulse && conv_clock_select[1:0] == asq_pkg::RC_CODE);
    cover_restart_c: cover property (state_reg == asq_pkg::ST_RECOVER && start_reg);
endmodule
`default_nettype wire

// >>> tb/asq_analog_model.sv
`default_nettype none
module asq_analog_model #(
    parameter int RC_PER = 10
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // front end
    input wire asq_pkg::asq_analog_s ana,
    input wire logic [9:0] level,
    output logic comp_above,
    output logic rc_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] held_reg;
    logic [7:0] rc_cnt_reg;
    // hold cap tracks input only while connected
    always_ff @(posedge sys_clk) begin
        if (ana.sample_connect) begin
            held_reg <= level;
        end
    end
    assign comp_above = (held_reg >= ana.sar_trial);
    // rc oscillator runs free, not tied to frames
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rc_cnt_reg <= 8'h00;
        end else begin
            rc_cnt_reg <= (rc_cnt_reg == 8'(RC_PER - 1)) ? 8'h00 : rc_cnt_reg + 8'h01;
        end
    end
    assign rc_tick = (rc_cnt_reg == 8'h00);
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RC_PER = 10;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic sleep_active = 1'b0;
    logic [9:0] level = 10'h000;
    asq_pkg::asq_bus_req_s req = '0;
    logic [7:0] rd_data;
    asq_pkg::asq_analog_s ana;
    logic comp_above;
    logic rc_tick;
    logic done_flag;
    logic irq_en;
    int bad_count = 0;
    int checks_done = 0;
    typedef struct packed {logic [7:0] timing; logic sleep; logic [9:0] lvl;} asq_row_s;
    // every acquisition and clock code once; last row converts asleep on rc
    asq_row_s rows [8] = '{{8'h80, 1'b0, 10'h3ff}, {8'h09, 1'b0, 10'h000},
                           {8'h92, 1'b0, 10'h155}, {8'h1b, 1'b0, 10'h2aa},
                           {8'ha4, 1'b0, 10'h201}, {8'h2d, 1'b0, 10'h1ff},
                           {8'hb6, 1'b0, 10'h0ff}, {8'h3f, 1'b1, 10'h3c3}};
    int divs [8] = '{2, 8, 32, RC_PER, 4, 16, 64, RC_PER};
    int acqs [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    logic [7:0] d;
    logic [7:0] hi;
    logic [7:0] lo;
    int n;
    int addrs [5] = '{0, 1, 2, 5, 6};

    always #25 sys_clk = ~sys_clk;

    asq_sequencer uut (.sys_clk(sys_clk), .rstn(rstn), .bus_req(req), .rd_data(rd_data),
        .comp_above(comp_above), .rc_tick(rc_tick), .sleep_active(sleep_active),
        .ana_out(ana), .conversion_done_flag(done_flag), .conversion_irq_enable(irq_en));
    asq_analog_model #(.RC_PER(RC_PER)) model (.sys_clk(sys_clk), .rstn(rstn), .ana(ana),
        .level(level), .comp_above(comp_above), .rc_tick(rc_tick));

    task automatic give_verdict();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 v = rd_data;
    endtask
    task automatic wait_idle(output int cyc);
        logic [7:0] c;
        cyc = 0;
        c = 8'h02;
        while (c[1] !== 1'b0 && cyc < 8000) begin
            rd(3'h0, c);
            cyc += 2;
        end
        if (cyc >= 8000) begin
            bad_count++;
            $display("mismatch at %0t: conversion never finished", $time);
            give_verdict();
        end
    endtask
    task automatic check_pair(input logic [9:0] t, input logic right);
        rd(3'h3, hi);
        rd(3'h4, lo);
        cmp8(hi, right ? {6'h00, t[9:8]} : t[9:2]);
        cmp8(lo, right ? t[7:0] : {t[1:0], 6'h00});
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (addrs[i]) begin
            rd(3'(addrs[i]), d);
            cmp8(d, 8'h00);
        end
        wr(3'h0, 8'h02);
        rd(3'h0, d);
        cmp8(d, 8'h00);
        wr(3'h0, 8'h03);
        rd(3'h0, d);
        cmp8(d, 8'h01);
        wr(3'h1, 8'h35);
        rd(3'h1, d);
        cmp8(d, 8'h35);
        cmp8({4'h0, ana.port_cfg}, 8'h05);
        cmp1(ana.vref_pos_ext, 1'b1);
        cmp1(ana.vref_neg_ext, 1'b1);
        wr(3'h2, 8'hff);
        rd(3'h2, d);
        cmp8(d, 8'hbf);
        wr(3'h5, 8'h02);
        rd(3'h5, d);
        cmp8(d, 8'h02);
        cmp1(irq_en, 1'b1);
        foreach (rows[i]) begin
            @(posedge sys_clk);
            level <= rows[i].lvl;
            sleep_active <= rows[i].sleep;
            wr(3'h2, rows[i].timing);
            wr(3'h0, 8'h07);
            wait_idle(n);
            // duration from acq and divider tables
            cmp1(n >= (acqs[i] + 10) * divs[i] &&
                 n <= (acqs[i] + 13) * divs[i] + 12, 1'b1);
            check_pair(rows[i].lvl, rows[i].timing[7]);
            cmp1(done_flag, 1'b1);
            wr(3'h5, 8'h00);
            sleep_active <= 1'b0;
            repeat (200) @(posedge sys_clk);
            cmp1(ana.sample_connect, 1'b1);
            cmp8({4'h0, ana.channel}, 8'h01);
        end
        // zero acquisition: hold cap drops right after start
        level <= 10'h123;
        wr(3'h2, 8'h80);
        wr(3'h0, 8'h03);
        repeat (2) @(posedge sys_clk);
        #1 cmp1(ana.sample_connect, 1'b0);
        wait_idle(n);
        cmp1(ana.sample_connect, 1'b0);
        repeat (10) @(posedge sys_clk);
        cmp1(ana.sample_connect, 1'b1);
        wr(3'h5, 8'h00);
        // long acquisition, then abort in conversion
        level <= 10'h2f0;
        wr(3'h2, 8'hb8);
        wr(3'h0, 8'h03);
        repeat (10) @(posedge sys_clk);
        cmp1(ana.sample_connect, 1'b1);
        rd(3'h0, d);
        cmp8(d, 8'h03);
        repeat (40) @(posedge sys_clk);
        rd(3'h0, d);
        cmp8(d, 8'h03);
        wr(3'h0, 8'h01);
        rd(3'h0, d);
        cmp8(d, 8'h01);
        check_pair(10'h123, 1'b1);
        cmp1(done_flag, 1'b0);
        // divided source freezes while asleep
        repeat (20) @(posedge sys_clk);
        sleep_active <= 1'b1;
        wr(3'h2, 8'h80);
        wr(3'h0, 8'h03);
        repeat (100) @(posedge sys_clk);
        rd(3'h0, d);
        cmp8(d, 8'h03);
        @(posedge sys_clk);
        sleep_active <= 1'b0;
        wait_idle(n);
        check_pair(10'h2f0, 1'b1);
        // reset in mid conversion
        repeat (20) @(posedge sys_clk);
        wr(3'h0, 8'h03);
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        cmp1(ana.sample_connect, 1'b0);
        cmp1(done_flag, 1'b0);
        rstn <= 1'b1;
        rd(3'h0, d);
        cmp8(d, 8'h00);
        rd(3'h2, d);
        cmp8(d, 8'h00);
        check_pair(10'h2f0, 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
